// ===== src/rfb_pkg.sv
// shared constants and carriers for the regulator fault register bank
package rfb_pkg;

  // ==========================================================================
  // register map
  localparam logic [7:0] OFF_ID    = 8'h00;
  localparam logic [7:0] OFF_FLAGS = 8'h01;
  localparam logic [7:0] OFF_STAT  = 8'h02;
  localparam logic [7:0] OFF_MODE  = 8'h03;
  localparam logic [7:0] OFF_OUTPUT_VOLTAGE_TARGET  = 8'h04;
  localparam logic [7:0] OFF_OUTPUT_VOLTAGE_FLOOR  = 8'h05;
  localparam logic [7:0] OFF_OUTPUT_VOLTAGE_CEILING  = 8'h06;
  localparam logic [7:0] OFF_SHUT  = 8'h07;
  localparam logic [7:0] OFF_ILIM  = 8'h08;
  localparam logic [7:0] OFF_SWRST = 8'h09;

  // ==========================================================================
  // field positions
  localparam int MODE_EN_BIT   = 7;
  localparam int MODE_FPWM_BIT = 6;
  localparam int MODE_LOCK_BIT = 5;
  localparam int MODE_SST_BIT  = 4;
  localparam int MODE_RAMP_BIT = 3;
  localparam int FLG_ILIM      = 0;
  localparam int FLG_SHORT     = 1;
  localparam int FLG_OT        = 2;
  localparam int FLG_UV        = 3;
  localparam int FLG_STO       = 4;

  // ==========================================================================
  // reset values
  localparam logic [4:0] FLAGS_RST = 5'h00;
  localparam logic [7:0] MODE_RST  = 8'h00;
  localparam logic [7:0] OUTPUT_VOLTAGE_TARGET_RST  = 8'h00;
  localparam logic [7:0] OUTPUT_VOLTAGE_FLOOR_RST  = 8'h00;
  localparam logic [7:0] OUTPUT_VOLTAGE_CEILING_RST  = 8'hFF;
  localparam logic [7:0] SHUT_RST  = 8'h00;
  localparam logic [7:0] ILIM_RST  = 8'h00;
  localparam logic       PWM_RST   = 1'b1;
  localparam logic [8:0] SYNC_RST  = 9'h180;

  // ==========================================================================
  // timing
  localparam int          CLK_NS        = 8;
  localparam int          TICK_NS       = 1000;
  localparam int          TICK_CYC      = TICK_NS / CLK_NS;
  localparam logic [6:0]  TICK_LAST     = 7'(TICK_CYC - 1);
  localparam int          SCL_LOW_MS    = 100;
  localparam int          SCL_LOW_TICKS = SCL_LOW_MS * 1000000 / TICK_NS;
  localparam int          ILIM_HOLD_US  = 500;
  localparam logic [16:0] ILIM_LAST     = 17'(ILIM_HOLD_US * 1000 / TICK_NS - 1);
  localparam int          HICCUP_MS     = 20;
  localparam int          HICCUP_TICKS  = HICCUP_MS * 1000000 / TICK_NS;

  // ==========================================================================
  // carriers
  typedef struct packed {
    logic load_ge_pwm_entry_current;
    logic load_lt_pfm_return_current;
    logic input_undervoltage_status;
    logic over_temp;
    logic vout_short;
    logic peak_current_limit;
    logic startup_timeout;
  } rfb_sense_t;

  typedef struct packed {
    logic       buck_on;
    logic       pwm_mode;
    logic [7:0] vout_code;
    logic       voltage_ramp_enable;
    logic [2:0] voltage_ramp_rate;
    logic       ss_timeout;
    logic [7:0] shutdown_opts;
    logic [3:0] pfm_ilim;
    logic [3:0] pwm_ilim;
  } rfb_ctrl_t;

endpackage

// ===== src/rfb_sync.sv
// two-flop synchroniser for a vector of asynchronous levels
`timescale 1ns/1ps
module rfb_sync #(
  parameter int           W   = 1,
  parameter logic [W-1:0] RST = '0
)(
  input  wire logic         i_clk,
  input  wire logic         i_rst,
  input  wire logic [W-1:0] i_d,
  output logic      [W-1:0] o_q
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] q_ff;

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      meta_ff <= RST;
      q_ff    <= RST;
    end
    else
    begin
      meta_ff <= i_d;
      q_ff    <= meta_ff;
    end
  end

  assign o_q = q_ff;
endmodule

// ===== src/rfb_top.sv
// regulator fault register bank behind a two-wire serial slave
`timescale 1ns/1ps
module rfb_top #(
  parameter logic [6:0]  P_DEV_ADDR      = 7'h20,
  parameter logic [3:0]  P_PART_CODE     = 4'hA,  // arbitrary value
  parameter logic [3:0]  P_SI_REV        = 4'h3,  // arbitrary value
  parameter logic [16:0] P_SCL_LOW_TICKS = 17'(rfb_pkg::SCL_LOW_TICKS),
  parameter logic [16:0] P_HICCUP_TICKS  = 17'(rfb_pkg::HICCUP_TICKS)
)(
  input  wire logic                i_clk,
  input  wire logic                i_rst,
  input  wire logic                i_scl,
  input  wire logic                i_sda,
  output logic                     o_sda,
  output logic                     o_sda_oe_n,
  input  wire rfb_pkg::rfb_sense_t i_sense,
  output rfb_pkg::rfb_ctrl_t       o_ctrl
);
  import rfb_pkg::*;

  typedef enum logic [3:0] {ST_IDLE, ST_START, ST_ADDR, ST_ADDR_ACK, ST_PTR, ST_PTR_ACK,
                            ST_WDATA, ST_WDATA_ACK, ST_RDATA, ST_RDATA_ACK} rfb_st_t;

  // ==========================================================================
  // synchronised inputs and edges
  logic [8:0]  sync_q;
  rfb_sense_t  sns;
  logic        scl_d_ff;
  logic        sda_d_ff;
  rfb_sense_t  sns_d_ff;

  rfb_sync #(.W(9), .RST(SYNC_RST)) u_sync (
    .i_clk (i_clk),
    .i_rst (i_rst),
    .i_d   ({i_scl, i_sda, i_sense}),
    .o_q   (sync_q)
  );

  wire scl_s    = sync_q[8];
  wire sda_s    = sync_q[7];
  assign sns    = sync_q[6:0];
  wire scl_rise = scl_s & ~scl_d_ff;
  wire scl_fall = ~scl_s & scl_d_ff;
  wire start_c  = scl_s & scl_d_ff & sda_d_ff & ~sda_s;
  wire stop_c   = scl_s & scl_d_ff & ~sda_d_ff & sda_s;
  wire ot_rise  = sns.over_temp & ~sns_d_ff.over_temp;
  wire uv_rise  = sns.input_undervoltage_status & ~sns_d_ff.input_undervoltage_status;
  wire sh_rise  = sns.vout_short & ~sns_d_ff.vout_short;
  wire sto_rise = sns.startup_timeout & ~sns_d_ff.startup_timeout;

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      scl_d_ff <= 1'b1;
      sda_d_ff <= 1'b1;
      sns_d_ff <= '0;
    end
    else
    begin
      scl_d_ff <= scl_s;
      sda_d_ff <= sda_s;
      sns_d_ff <= sns;
    end
  end

  // ==========================================================================
  // microsecond tick and timers
  logic [6:0]  tick_cnt_ff;
  logic [16:0] scl_lo_ff;
  logic [16:0] ilim_cnt_ff;
  logic [16:0] hic_cnt_ff;
  logic [7:0]  mode_ff;
  logic        wr_stb;
  logic [7:0]  sh_ff;
  logic [7:0]  ptr_ff;

  wire tick      = (tick_cnt_ff == TICK_LAST);
  wire hic_on    = (hic_cnt_ff != 17'h0);
  wire run       = mode_ff[MODE_EN_BIT] & ~hic_on;
  // saturates one past the limit so a long hold fires once only
  wire scl_lo_hit = tick & ~scl_s & (scl_lo_ff == P_SCL_LOW_TICKS);
  wire ilim_trip = tick & run & sns.peak_current_limit & (ilim_cnt_ff == ILIM_LAST);
  wire sw_rst    = wr_stb & (ptr_ff == OFF_SWRST);
  wire reg_clr   = scl_lo_hit | sw_rst;

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      tick_cnt_ff <= 7'h00;
    else
      tick_cnt_ff <= tick ? 7'h00 : tick_cnt_ff + 7'h01;
  end

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      scl_lo_ff <= 17'h0;
    else if (scl_s)
      scl_lo_ff <= 17'h0;
    else if (tick && scl_lo_ff <= P_SCL_LOW_TICKS)
      scl_lo_ff <= scl_lo_ff + 17'h1;
  end

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      ilim_cnt_ff <= 17'h0;
    else if (!run || !sns.peak_current_limit)
      ilim_cnt_ff <= 17'h0;
    else if (tick)
      ilim_cnt_ff <= ilim_cnt_ff + 17'h1;
  end

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      hic_cnt_ff <= 17'h0;
    else if (ilim_trip)
      hic_cnt_ff <= P_HICCUP_TICKS;
    else if (tick && hic_on)
      hic_cnt_ff <= hic_cnt_ff - 17'h1;
  end

  // ==========================================================================
  // register file
  logic [4:0] flags_ff;
  logic [7:0] output_voltage_target_ff;
  logic [7:0] output_voltage_floor_ff;
  logic [7:0] output_voltage_ceiling_ff;
  logic [7:0] shut_ff;
  logic [7:0] ilim_ff;
  logic       pwm_ff;
  logic       rd_take;
  logic [7:0] nxt_mode;
  logic [7:0] rd_data;
  rfb_ctrl_t  ctrl_ff;

  wire wr_mode  = wr_stb & (ptr_ff == OFF_MODE);
  wire en_req   = wr_mode & sh_ff[MODE_EN_BIT];
  wire en_uv    = en_req & sns.input_undervoltage_status;
  wire flag_rd  = rd_take & (ptr_ff == OFF_FLAGS);
  wire uv_set   = en_uv | (uv_rise & mode_ff[MODE_EN_BIT]);
  // set wins over the read clear so a fault in the read cycle is kept
  wire [4:0] set_vec = {sto_rise, uv_set, ot_rise, sh_rise, ilim_trip};
  wire [4:0] nxt_flags = (flag_rd ? FLAGS_RST : flags_ff) | set_vec;
  wire [7:0] vclamp = (sh_ff > output_voltage_ceiling_ff) ? output_voltage_ceiling_ff : (sh_ff < output_voltage_floor_ff) ? output_voltage_floor_ff : sh_ff;
  wire       ready  = ~mode_ff[MODE_EN_BIT] & ~sns.input_undervoltage_status & ~sns.over_temp;
  wire [7:0] stat_byte = {1'b0, ready, 1'b0, pwm_ff, sns.input_undervoltage_status,
                          sns.over_temp, sns.vout_short & mode_ff[MODE_EN_BIT],
                          sns.peak_current_limit};

  always_comb
  begin
    nxt_mode = wr_mode ? sh_ff : mode_ff;
    if (en_uv || ot_rise || (uv_rise && mode_ff[MODE_EN_BIT]))
      nxt_mode[MODE_EN_BIT] = 1'b0;
  end

  assign rd_data = (ptr_ff == OFF_ID)    ? {P_PART_CODE, P_SI_REV} :
                   (ptr_ff == OFF_FLAGS) ? {3'h0, flags_ff} :
                   (ptr_ff == OFF_STAT)  ? stat_byte :
                   (ptr_ff == OFF_MODE)  ? mode_ff :
                   (ptr_ff == OFF_OUTPUT_VOLTAGE_TARGET)  ? output_voltage_target_ff :
                   (ptr_ff == OFF_OUTPUT_VOLTAGE_FLOOR)  ? output_voltage_floor_ff :
                   (ptr_ff == OFF_OUTPUT_VOLTAGE_CEILING)  ? output_voltage_ceiling_ff :
                   (ptr_ff == OFF_SHUT)  ? shut_ff :
                   (ptr_ff == OFF_ILIM)  ? ilim_ff : 8'h00;

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      flags_ff <= FLAGS_RST;
      mode_ff  <= MODE_RST;
      output_voltage_target_ff  <= OUTPUT_VOLTAGE_TARGET_RST;
      output_voltage_floor_ff  <= OUTPUT_VOLTAGE_FLOOR_RST;
      output_voltage_ceiling_ff  <= OUTPUT_VOLTAGE_CEILING_RST;
      shut_ff  <= SHUT_RST;
      ilim_ff  <= ILIM_RST;
    end
    else if (reg_clr)
    begin
      flags_ff <= FLAGS_RST;
      mode_ff  <= MODE_RST;
      output_voltage_target_ff  <= OUTPUT_VOLTAGE_TARGET_RST;
      output_voltage_floor_ff  <= OUTPUT_VOLTAGE_FLOOR_RST;
      output_voltage_ceiling_ff  <= OUTPUT_VOLTAGE_CEILING_RST;
      shut_ff  <= SHUT_RST;
      ilim_ff  <= ILIM_RST;
    end
    else
    begin
      flags_ff <= nxt_flags;
      mode_ff  <= nxt_mode;
      if (wr_stb && ptr_ff == OFF_OUTPUT_VOLTAGE_TARGET)
        output_voltage_target_ff <= vclamp;
      if (wr_stb && ptr_ff == OFF_OUTPUT_VOLTAGE_FLOOR)
        output_voltage_floor_ff <= sh_ff;
      if (wr_stb && ptr_ff == OFF_OUTPUT_VOLTAGE_CEILING)
        output_voltage_ceiling_ff <= sh_ff;
      if (wr_stb && ptr_ff == OFF_SHUT)
        shut_ff <= sh_ff;
      // locked limits ignore writes while MODE_LOCK_BIT is set; a mode write with the bit clear or a reset clears it
      if (wr_stb && ptr_ff == OFF_ILIM && !mode_ff[MODE_LOCK_BIT])
        ilim_ff <= sh_ff;
    end
  end

  // idle forces the default pwm indication
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      pwm_ff <= PWM_RST;
    else if (!mode_ff[MODE_EN_BIT] || mode_ff[MODE_FPWM_BIT])
      pwm_ff <= PWM_RST;
    else if (sns.load_ge_pwm_entry_current)
      pwm_ff <= 1'b1;
    else if (sns.load_lt_pfm_return_current)
      pwm_ff <= 1'b0;
  end

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      ctrl_ff <= '0;
    else
      ctrl_ff <= '{run, pwm_ff, output_voltage_target_ff, mode_ff[MODE_RAMP_BIT], mode_ff[2:0],
                   mode_ff[MODE_SST_BIT], shut_ff, ilim_ff[7:4], ilim_ff[3:0]};
  end
  assign o_ctrl = ctrl_ff;

  // ==========================================================================
  // serial slave
  rfb_st_t    st_ff, nxt_st;
  logic [2:0] bit_ff, nxt_bit;
  logic [7:0] nxt_sh, tx_ff, nxt_tx, nxt_ptr;
  logic       rw_ff, nxt_rw, ack_ff, nxt_ack, drv_ff, nxt_drv;

  wire last_bit = (bit_ff == 3'h7);

  always_comb
  begin
    nxt_st  = st_ff;
    nxt_bit = bit_ff;
    nxt_sh  = sh_ff;
    nxt_tx  = tx_ff;
    nxt_ptr = ptr_ff;
    nxt_rw  = rw_ff;
    nxt_ack = ack_ff;
    nxt_drv = drv_ff;
    wr_stb  = 1'b0;
    rd_take = 1'b0;
    if (scl_lo_hit || stop_c)
    begin
      nxt_st  = ST_IDLE;
      nxt_drv = 1'b0;
    end
    else if (start_c)
    begin
      nxt_st  = ST_START;
      nxt_drv = 1'b0;
    end
    else if (scl_rise)
    begin
      if (st_ff == ST_RDATA_ACK)
        nxt_ack = ~sda_s;
      else
        nxt_sh = {sh_ff[6:0], sda_s};
    end
    else if (scl_fall)
    begin
      nxt_bit = bit_ff + 3'h1;
      unique case (st_ff)
        ST_IDLE: ;
        ST_START:
        begin
          nxt_st  = ST_ADDR;
          nxt_bit = 3'h0;
        end
        ST_ADDR:
          if (last_bit)
          begin
            nxt_rw  = sh_ff[0];
            nxt_drv = (sh_ff[7:1] == P_DEV_ADDR);
            nxt_st  = nxt_drv ? ST_ADDR_ACK : ST_IDLE;
          end
        ST_PTR:
          if (last_bit)
          begin
            nxt_ptr = sh_ff;
            nxt_drv = 1'b1;
            nxt_st  = ST_PTR_ACK;
          end
        ST_WDATA:
          if (last_bit)
          begin
            // soft reset drops the bus here; gating on reg_clr above would loop
            wr_stb  = 1'b1;
            nxt_drv = (ptr_ff != OFF_SWRST);
            nxt_st  = nxt_drv ? ST_WDATA_ACK : ST_IDLE;
          end
        ST_RDATA:
        begin
          nxt_tx  = {tx_ff[6:0], 1'b0};
          nxt_drv = ~tx_ff[6];
          if (last_bit)
          begin
            nxt_drv = 1'b0;
            nxt_ptr = ptr_ff + 8'h01;
            nxt_st  = ST_RDATA_ACK;
          end
        end
        ST_ADDR_ACK, ST_PTR_ACK, ST_WDATA_ACK, ST_RDATA_ACK:
        begin
          nxt_bit = 3'h0;
          nxt_drv = 1'b0;
          if (st_ff == ST_WDATA_ACK)
            nxt_ptr = ptr_ff + 8'h01;
          if (st_ff == ST_PTR_ACK || st_ff == ST_WDATA_ACK)
            nxt_st = ST_WDATA;
          else if (st_ff == ST_ADDR_ACK && !rw_ff)
            nxt_st = ST_PTR;
          else if (st_ff == ST_RDATA_ACK && !ack_ff)
            nxt_st = ST_IDLE;
          else
          begin
            nxt_st  = ST_RDATA;
            nxt_tx  = rd_data;
            rd_take = 1'b1;
            nxt_drv = ~rd_data[7];
          end
        end
      endcase
    end
  end

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      st_ff  <= ST_IDLE;
      bit_ff <= 3'h0;
      sh_ff  <= 8'h00;
      tx_ff  <= 8'h00;
      ptr_ff <= 8'h00;
      rw_ff  <= 1'b0;
      ack_ff <= 1'b0;
      drv_ff <= 1'b0;
    end
    else
    begin
      st_ff  <= nxt_st;
      bit_ff <= nxt_bit;
      sh_ff  <= nxt_sh;
      tx_ff  <= nxt_tx;
      ptr_ff <= nxt_ptr;
      rw_ff  <= nxt_rw;
      ack_ff <= nxt_ack;
      drv_ff <= nxt_drv;
    end
  end

  // open drain: only ever pulls low
  assign o_sda      = 1'b0;
  assign o_sda_oe_n = ~drv_ff;

  // ==========================================================================
  // assertions
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  scl_hw_reset_a: assert property (scl_lo_hit |=> mode_ff == MODE_RST && flags_ff == FLAGS_RST)
    else $error("clock-low reset did not restore defaults");
  pwm_entry_a: assert property (mode_ff[MODE_EN_BIT] && sns.load_ge_pwm_entry_current |=> pwm_ff)
    else $error("no pwm at entry current");
  pfm_return_a: assert property (mode_ff[MODE_EN_BIT] && !mode_ff[MODE_FPWM_BIT]
    && !sns.load_ge_pwm_entry_current && sns.load_lt_pfm_return_current |=> !pwm_ff)
    else $error("no pfm below return current");
  sto_latch_a: assert property (sto_rise && !reg_clr |=> flags_ff[FLG_STO])
    else $error("startup timeout not latched");
  uv_hold_a: assert property (flags_ff[FLG_UV] && !flag_rd && !reg_clr |=> flags_ff[FLG_UV])
    else $error("undervoltage flag lost before read");
  ot_latch_a: assert property (ot_rise && !reg_clr |=> flags_ff[FLG_OT] && !mode_ff[MODE_EN_BIT])
    else $error("over-temperature not handled");
  read_clear_a: assert property (flag_rd && set_vec == 5'h00 && !reg_clr |=> flags_ff == 5'h00)
    else $error("flag read did not clear");
  ilim_hiccup_a: assert property (ilim_trip |=> flags_ff[FLG_ILIM] && hic_on && !run ##1 !ctrl_ff.buck_on)
    else $error("current limit fault did not stop the regulator");
  flags_upper_a: assert property (ptr_ff == OFF_FLAGS |-> rd_data[7:5] == 3'h0)
    else $error("flag upper bits not zero");
  uv_enable_a: assert property (en_uv && !reg_clr |=> !mode_ff[MODE_EN_BIT] && flags_ff[FLG_UV])
    else $error("enable accepted during undervoltage");
  scl_restart_a: assert property (scl_s |=> scl_lo_ff == 17'h0)
    else $error("clock-low count not restarted");

  cover_write_c: cover property (wr_mode && sh_ff[MODE_EN_BIT]);
  cover_flag_rd_c: cover property (flag_rd && flags_ff != 5'h00);
  cover_hiccup_c: cover property (ilim_trip);
  cover_hw_rst_c: cover property (scl_lo_hit);
endmodule

// ===== tb/rfb_host.sv
// two-wire serial host model that drives the register bank's bus pins
`timescale 1ns/1ps
module rfb_host #(
  parameter logic [6:0] P_ADDR = 7'h20
)(
  input  wire logic i_clk,
  input  wire logic i_sda_line,
  output logic      o_scl,
  output logic      o_sda
);
  // ==========================================================================
  // bit level, all changes just after a falling clock edge
  initial
  begin
    o_scl = 1'b1;
    o_sda = 1'b1;
  end

  task automatic cyc(input int n);
    repeat (n) @(negedge i_clk);
  endtask

  task automatic start_c();
    o_sda = 1'b1;
    cyc(5);
    o_scl = 1'b1;
    cyc(5);
    o_sda = 1'b0;
    cyc(5);
    o_scl = 1'b0;
    cyc(1);
  endtask

  task automatic stop_c();
    o_sda = 1'b0;
    cyc(5);
    o_scl = 1'b1;
    cyc(5);
    o_sda = 1'b1;
    cyc(5);
  endtask

  // one clock after the fall before data moves, so no false start is seen
  task automatic bit_c(input logic b, output logic r);
    o_sda = b;
    cyc(5);
    o_scl = 1'b1;
    cyc(5);
    r     = i_sda_line;
    o_scl = 1'b0;
    cyc(1);
  endtask

  // ==========================================================================
  // byte and register level
  task automatic byte_w(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_c(d[i], r);
    bit_c(1'b1, r);
    ack = ~r;
  endtask

  task automatic write_reg(input logic [7:0] p, input logic [7:0] d, output logic ok);
    logic a0, a1, a2;
    start_c();
    byte_w({P_ADDR, 1'b0}, a0);
    byte_w(p, a1);
    byte_w(d, a2);
    stop_c();
    ok = a0 & a1 & a2;
  endtask

  task automatic read_reg(input logic [7:0] p, output logic [7:0] d, output logic ok);
    logic a0, a1, a2, r;
    start_c();
    byte_w({P_ADDR, 1'b0}, a0);
    byte_w(p, a1);
    start_c();
    byte_w({P_ADDR, 1'b1}, a2);
    for (int i = 7; i >= 0; i--)
      bit_c(1'b1, d[i]);
    bit_c(1'b1, r);
    stop_c();
    ok = a0 & a1 & a2;
  endtask

  task automatic probe(input logic [6:0] a, output logic ack);
    start_c();
    byte_w({a, 1'b0}, ack);
    stop_c();
  endtask

  // clock line held low while idle, data line left high
  task automatic hold_low(input int n);
    o_scl = 1'b0;
    cyc(n);
    o_scl = 1'b1;
    cyc(5);
  endtask
endmodule

// ===== tb/tb_top.sv
// self-checking testbench for the regulator fault register bank
`timescale 1ns/1ps
module tb_top;
  import rfb_pkg::*;
  localparam logic [3:0] PART = 4'h5;  // arbitrary value
  localparam logic [3:0] REV  = 4'h2;  // arbitrary value
  logic       clk;
  logic       rst;
  logic       scl;
  logic       host_sda;
  logic       dut_sda;
  logic       dut_oe_n;
  wire        sda_line;
  rfb_sense_t sense;
  rfb_ctrl_t  ctrl;
  int         n_errors;
  int         check_count;
  logic [7:0] rd;
  logic       ok;
  int         sidx[3] = '{0, 2, 3};
  int         fidx[3] = '{FLG_STO, FLG_SHORT, FLG_OT};

  // open-drain data line with pull-up
  assign sda_line = host_sda & (dut_oe_n | dut_sda);

  rfb_top #(
    .P_PART_CODE     (PART),
    .P_SI_REV        (REV),
    .P_SCL_LOW_TICKS (17'h00005),
    .P_HICCUP_TICKS  (17'h00005)
  ) i_dut (
    .i_clk      (clk),
    .i_rst      (rst),
    .i_scl      (scl),
    .i_sda      (sda_line),
    .o_sda      (dut_sda),
    .o_sda_oe_n (dut_oe_n),
    .i_sense    (sense),
    .o_ctrl     (ctrl)
  );

  rfb_host i_host (
    .i_clk      (clk),
    .i_sda_line (sda_line),
    .o_scl      (scl),
    .o_sda      (host_sda)
  );

  always #4 clk = ~clk;

  // ==========================================================================
  // helpers
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic stop_test();
    if (n_errors == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic wr(input logic [7:0] p, input logic [7:0] d);
    i_host.write_reg(p, d, ok);
    check("write ack", {7'h00, ok}, 8'h01);
  endtask

  task automatic rchk(input string name, input logic [7:0] p, input logic [7:0] exp);
    i_host.read_reg(p, rd, ok);
    check("read ack", {7'h00, ok}, 8'h01);
    check(name, rd, exp);
  endtask

  // sel 0 watches buck_on, sel 1 watches pwm_mode
  task automatic wctl(input string name, input int sel, input logic v, input int lim);
    int n;
    n = 0;
    while (((sel == 0) ? ctrl.buck_on : ctrl.pwm_mode) !== v && n < lim)
    begin
      @(negedge clk);
      n++;
    end
    check(name, {7'h00, (sel == 0) ? ctrl.buck_on : ctrl.pwm_mode}, {7'h00, v});
    if (n >= lim)
      stop_test();
  endtask

  // ==========================================================================
  // main sequence
  initial
  begin
    clk         = 1'b0;
    rst         = 1'b1;
    sense       = '0;
    n_errors    = 0;
    check_count = 0;
    repeat (10) @(negedge clk);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    rchk("id", OFF_ID, {PART, REV});
    rchk("flags", OFF_FLAGS, 8'h00);
    rchk("mode", OFF_MODE, MODE_RST);
    rchk("ceiling", OFF_OUTPUT_VOLTAGE_CEILING, OUTPUT_VOLTAGE_CEILING_RST);
    rchk("unmapped", 8'h0A, 8'h00);
    wr(OFF_ID, 8'hFF);
    rchk("id ro", OFF_ID, {PART, REV});
    wr(OFF_FLAGS, 8'hFF);
    rchk("flags upper", OFF_FLAGS, 8'h00);
    i_host.probe(7'h21, ok);
    check("foreign addr", {7'h00, ok}, 8'h00);
    // target clamps to floor and ceiling; a set lock refuses limit writes
    wr(OFF_OUTPUT_VOLTAGE_FLOOR, 8'h20);
    wr(OFF_OUTPUT_VOLTAGE_CEILING, 8'h40);
    wr(OFF_OUTPUT_VOLTAGE_TARGET, 8'h50);
    rchk("output_voltage_target ceiling", OFF_OUTPUT_VOLTAGE_TARGET, 8'h40);
    wr(OFF_OUTPUT_VOLTAGE_TARGET, 8'h10);
    rchk("output_voltage_target floor", OFF_OUTPUT_VOLTAGE_TARGET, 8'h20);
    wr(OFF_SHUT, 8'h03);
    wr(OFF_ILIM, 8'h5A);
    wr(OFF_MODE, 8'h3B);
    wr(OFF_ILIM, 8'h33);
    rchk("ilim locked", OFF_ILIM, 8'h5A);
    // idle with no fault: ready set and the default pwm indication
    rchk("status idle", OFF_STAT, 8'h50);
    check("vout code", ctrl.vout_code, 8'h20);
    check("shutdown", ctrl.shutdown_opts, 8'h03);
    check("limits", {ctrl.pfm_ilim, ctrl.pwm_ilim}, 8'h5A);
    check("ramp", {3'h0, ctrl.voltage_ramp_enable, ctrl.ss_timeout,
                   ctrl.voltage_ramp_rate}, 8'h1B);
    // soft reset ends the transfer at the strobe, so its data byte is not answered
    i_host.write_reg(OFF_SWRST, 8'h01, ok);
    check("soft reset nack", {7'h00, ok}, 8'h00);
    rchk("floor soft", OFF_OUTPUT_VOLTAGE_FLOOR, OUTPUT_VOLTAGE_FLOOR_RST);
    rchk("ceiling soft", OFF_OUTPUT_VOLTAGE_CEILING, OUTPUT_VOLTAGE_CEILING_RST);
    rchk("ilim soft", OFF_ILIM, ILIM_RST);
    rchk("mode soft", OFF_MODE, MODE_RST);
    // latch on a short pulse, clear on the first read
    for (int k = 0; k < 3; k++)
    begin
      sense[sidx[k]] = 1'b1;
      repeat (10) @(negedge clk);
      sense[sidx[k]] = 1'b0;
      repeat (10) @(negedge clk);
      rchk("flag set", OFF_FLAGS, 8'(1 << fidx[k]));
      rchk("flag clear", OFF_FLAGS, 8'h00);
    end
    // enabling during undervoltage
    sense.input_undervoltage_status = 1'b1;
    wr(OFF_MODE, 8'h80);
    wctl("uv blocks", 0, 1'b0, 20);
    rchk("uv flag", OFF_FLAGS, 8'(1 << FLG_UV));
    rchk("uv mode", OFF_MODE, 8'h00);
    sense.input_undervoltage_status = 1'b0;
    // over-temperature while running
    wr(OFF_MODE, 8'h80);
    wctl("on", 0, 1'b1, 50);
    sense.over_temp = 1'b1;
    wctl("ot off", 0, 1'b0, 50);
    rchk("ot flag", OFF_FLAGS, 8'(1 << FLG_OT));
    rchk("ot mode", OFF_MODE, 8'h00);
    sense.over_temp = 1'b0;
    // undervoltage while running, flag holds until read
    wr(OFF_MODE, 8'h80);
    wctl("on", 0, 1'b1, 50);
    sense.input_undervoltage_status = 1'b1;
    wctl("uv off", 0, 1'b0, 50);
    repeat (200) @(negedge clk);
    rchk("uv latch", OFF_FLAGS, 8'(1 << FLG_UV));
    rchk("uv clear", OFF_FLAGS, 8'h00);
    sense.input_undervoltage_status = 1'b0;
    // load-driven switching between pfm and pwm, then forced pwm
    wr(OFF_MODE, 8'h80);
    wctl("on", 0, 1'b1, 50);
    sense.load_lt_pfm_return_current = 1'b1;
    wctl("to pfm", 1, 1'b0, 20);
    sense.load_ge_pwm_entry_current = 1'b1;
    wctl("to pwm", 1, 1'b1, 20);
    sense.load_ge_pwm_entry_current = 1'b0;
    wctl("back pfm", 1, 1'b0, 20);
    wr(OFF_MODE, 8'hC0);
    wctl("forced pwm", 1, 1'b1, 20);
    wr(OFF_MODE, 8'h80);
    wctl("unforced", 1, 1'b0, 20);
    sense.load_lt_pfm_return_current = 1'b0;
    // peak limit held 500 us, then a timed stop and restart
    sense.peak_current_limit = 1'b1;
    repeat (62000) @(negedge clk);
    check("still on", {7'h00, ctrl.buck_on}, 8'h01);
    wctl("hiccup", 0, 1'b0, 1000);
    sense.peak_current_limit = 1'b0;
    repeat (400) @(negedge clk);
    check("stays off", {7'h00, ctrl.buck_on}, 8'h00);
    wctl("restart", 0, 1'b1, 500);
    rchk("ilim flag", OFF_FLAGS, 8'(1 << FLG_ILIM));
    // clock-low reset: short lows restart the count, a long one resets
    wr(OFF_OUTPUT_VOLTAGE_TARGET, 8'h55);
    i_host.hold_low(375);
    i_host.hold_low(375);
    i_host.hold_low(375);
    rchk("output_voltage_target kept", OFF_OUTPUT_VOLTAGE_TARGET, 8'h55);
    i_host.hold_low(1000);
    rchk("output_voltage_target reset", OFF_OUTPUT_VOLTAGE_TARGET, OUTPUT_VOLTAGE_TARGET_RST);
    rchk("mode reset", OFF_MODE, MODE_RST);
    stop_test();
  end
endmodule
